/* File: olp_pkg.sv */
// Package with encodings, field positions and reset values for the OR/pointer-load executor
package olp_pkg;
   localparam int          OLP_DATA_W         = 8;
   localparam int          OLP_WORD_W         = 16;
   localparam int          OLP_LIT_W          = 12;
   localparam int          OLP_PTR_COUNT      = 3;
   localparam int          OLP_BANK_W         = 4;
   localparam int          OLP_ADDR_W         = 12;
   // Field positions in the instruction word
   localparam int          OLP_DEST_BIT       = 9;
   localparam int          OLP_ACCESS_BIT     = 8;
   localparam int          OLP_PTR_IDX_LSB    = 4;
   // Opcode patterns
   localparam logic [5:0]  OLP_OR_FILE_OP     = 6'h04;   // 0001 00
   localparam logic [9:0]  OLP_PTR_LOAD_OP1   = 10'h3B8; // 1110 1110 00
   localparam logic [7:0]  OLP_PTR_LOAD_OP2   = 8'hF0;   // 1111 0000
   // Access bank split point: low file addresses map to bank 0, high ones to the top bank
   localparam logic [7:0]  OLP_ACCESS_SPLIT   = 8'h60;
   localparam logic [3:0]  OLP_ACCESS_HI_BANK = 4'hF;
   // Reset values
   localparam logic [7:0]  OLP_W_RESET        = 8'h00;
   localparam logic [7:0]  OLP_PTR_RESET      = 8'h00;
   localparam logic [1:0]  OLP_PHASE_RESET    = 2'h0;

   typedef enum logic [1:0] {
      OLP_Q1_DECODE  = 2'b00,
      OLP_Q2_READ    = 2'b01,
      OLP_Q3_PROCESS = 2'b10,
      OLP_Q4_WRITE   = 2'b11
   } olp_phase_t;

   typedef enum logic [1:0] {
      OLP_OP_NONE     = 2'b00,
      OLP_OP_OR_FILE  = 2'b01,
      OLP_OP_PTR_HIGH = 2'b10,
      OLP_OP_PTR_LOW  = 2'b11
   } olp_op_t;
endpackage

/* File: olp_decode.sv */
// Instruction word decoder for the OR-with-file and pointer-load instructions
`timescale 1ns/100ps
module olp_decode
   import olp_pkg::*;
(
   input  wire logic [OLP_WORD_W-1:0] word,
   input  wire logic                  second_word_pending,
   output olp_op_t                    op,
   output logic                       dest_is_file,
   output logic                       use_bank_select,
   output logic [7:0]                 file_addr,
   output logic [1:0]                 ptr_idx,
   output logic [3:0]                 lit_high,
   output logic [7:0]                 lit_low
);
   wire is_or_file   = (word[15:10] == OLP_OR_FILE_OP);
   wire is_ptr_first = (word[15:6] == OLP_PTR_LOAD_OP1) && (word[5:4] != 2'b11);
   wire is_ptr_second = (word[15:8] == OLP_PTR_LOAD_OP2);

   assign op = second_word_pending ? (is_ptr_second ? OLP_OP_PTR_LOW : OLP_OP_NONE)
             : is_ptr_first ? OLP_OP_PTR_HIGH
             : is_or_file ? OLP_OP_OR_FILE : OLP_OP_NONE;
   assign dest_is_file    = word[OLP_DEST_BIT];
   assign use_bank_select = word[OLP_ACCESS_BIT];
   assign file_addr       = word[7:0];
   assign ptr_idx         = word[OLP_PTR_IDX_LSB +: 2];
   assign lit_high        = word[3:0];
   assign lit_low         = word[7:0];
endmodule // olp_decode

/* File: olp_exec.sv */
// Executor for OR-with-file and the two-word pointer-load instruction on a four-phase cycle
`timescale 1ns/100ps
module olp_exec
   import olp_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  reset_n,
   input  wire logic [OLP_WORD_W-1:0] instr_word,
   input  wire logic [OLP_BANK_W-1:0] bank_select_register,
   input  wire logic [OLP_DATA_W-1:0] file_rdata,
   output logic [OLP_ADDR_W-1:0]      file_addr,
   output logic                       file_rd,
   output logic                       file_we,
   output logic [OLP_DATA_W-1:0]      file_wdata,
   output logic [OLP_DATA_W-1:0]      w_reg,
   output logic                       flag_negative,
   output logic                       flag_zero,
   output logic [1:0]                 phase,
   output logic                       fetch_next,
   output logic [OLP_PTR_COUNT*OLP_LIT_W-1:0] indirect_pointer
);
   olp_phase_t                  phase_q;
   olp_op_t                     op_q;
   logic                        pend_q;
   logic [1:0]                  pidx_q;
   logic                        dest_q;
   logic [OLP_DATA_W-1:0]       result_q;
   logic [OLP_ADDR_W-1:0]       addr_q;
   logic                        rd_q;
   logic                        we_q;
   logic [OLP_DATA_W-1:0]       w_q;
   logic                        n_q;
   logic                        z_q;
   logic                        fetch_q;
   logic [3:0]                  lit_high_q;
   logic [7:0]                  lit_low_q;
   logic [OLP_LIT_W-4-1:0]      ptr_lo_q [OLP_PTR_COUNT];
   logic [3:0]                  ptr_hi_q [OLP_PTR_COUNT];

   olp_op_t                     dec_op;
   logic                        dec_dest;
   logic                        dec_bank;
   logic [7:0]                  dec_faddr;
   logic [1:0]                  dec_pidx;
   logic [3:0]                  dec_lhi;
   logic [7:0]                  dec_llo;

   olp_decode u_decode (
      .word                (instr_word),
      .second_word_pending (pend_q),
      .op                  (dec_op),
      .dest_is_file        (dec_dest),
      .use_bank_select     (dec_bank),
      .file_addr           (dec_faddr),
      .ptr_idx             (dec_pidx),
      .lit_high            (dec_lhi),
      .lit_low             (dec_llo)
   );

   // Access bank: addresses below OLP_ACCESS_SPLIT (8'h60) go to bank 0, the rest to the top bank
   wire [OLP_BANK_W-1:0] access_bank = (dec_faddr < OLP_ACCESS_SPLIT) ? '0 : OLP_ACCESS_HI_BANK;
   wire [OLP_BANK_W-1:0] eff_bank    = dec_bank ? bank_select_register : access_bank;
   wire [OLP_DATA_W-1:0] or_result   = w_q | file_rdata;
   wire                  ptr_valid   = (pidx_q < 2'(OLP_PTR_COUNT));

   // Four-phase sequencer
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         phase_q <= OLP_Q1_DECODE;
      end else begin
         phase_q <= olp_phase_t'(phase_q + 2'd1);
      end
   end

   // Q1: decode and latch the operation
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         op_q       <= OLP_OP_NONE;
         dest_q     <= 1'b0;
         addr_q     <= '0;
         lit_high_q <= '0;
         lit_low_q  <= '0;
      end else if (phase_q == OLP_Q1_DECODE) begin
         op_q       <= dec_op;
         dest_q     <= dec_dest;
         addr_q     <= {eff_bank, dec_faddr};
         lit_high_q <= dec_lhi;
         lit_low_q  <= dec_llo;
      end
   end

   // Second-word tracking and pointer index
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pend_q <= 1'b0;
         pidx_q <= '0;
      end else if (phase_q == OLP_Q1_DECODE) begin
         pend_q <= (dec_op == OLP_OP_PTR_HIGH);
         if (dec_op == OLP_OP_PTR_HIGH) begin
            pidx_q <= dec_pidx;
         end
      end
   end

   // Q2 file read strobe, Q3 OR process
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_q     <= 1'b0;
         result_q <= '0;
      end else begin
         rd_q <= (phase_q == OLP_Q1_DECODE) && (dec_op == OLP_OP_OR_FILE);
         if (phase_q == OLP_Q3_PROCESS && op_q == OLP_OP_OR_FILE) begin
            result_q <= or_result;
         end
      end
   end

   // Q4 destination write: file or W, plus N and Z
   wire q4_or = (phase_q == OLP_Q3_PROCESS) && (op_q == OLP_OP_OR_FILE);
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         we_q <= 1'b0;
         w_q  <= OLP_W_RESET;
         n_q  <= 1'b0;
         z_q  <= 1'b0;
      end else begin
         we_q <= q4_or && dest_q;
         if (q4_or && !dest_q) begin
            w_q <= or_result;
         end
         if (q4_or) begin
            n_q <= or_result[OLP_DATA_W-1];
            z_q <= (or_result == '0);
         end
      end
   end

   // Pointer bytes: high nibble in cycle one, low byte in cycle two; flags untouched
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < OLP_PTR_COUNT; i++) begin
            ptr_hi_q[i] <= OLP_PTR_RESET[3:0];
            ptr_lo_q[i] <= OLP_PTR_RESET;
         end
      end else if (phase_q == OLP_Q3_PROCESS && ptr_valid) begin
         if (op_q == OLP_OP_PTR_HIGH) begin
            ptr_hi_q[pidx_q] <= lit_high_q;
         end else if (op_q == OLP_OP_PTR_LOW) begin
            ptr_lo_q[pidx_q] <= lit_low_q;
         end
      end
   end

   // Next word requested at end of every cycle
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         fetch_q <= 1'b0;
      end else begin
         fetch_q <= (phase_q == OLP_Q3_PROCESS);
      end
   end

   assign file_addr     = addr_q;
   assign file_rd       = rd_q;
   assign file_we       = we_q;
   assign file_wdata    = result_q;
   assign w_reg         = w_q;
   assign flag_negative = n_q;
   assign flag_zero     = z_q;
   assign phase         = phase_q;
   assign fetch_next    = fetch_q;
   for (genvar g = 0; g < OLP_PTR_COUNT; g++) begin : g_ptr
      assign indirect_pointer[g*OLP_LIT_W +: OLP_LIT_W] = {ptr_hi_q[g], ptr_lo_q[g]};
   end
endmodule // olp_exec

/* File: olp_exec_props.sv */
// Concurrent checks on the OR/pointer-load executor ports
`timescale 1ns/100ps
module olp_exec_props
   import olp_pkg::*;
(
   input wire logic                  clk,
   input wire logic                  reset_n,
   input wire logic [OLP_DATA_W-1:0] file_rdata,
   input wire logic [OLP_ADDR_W-1:0] file_addr,
   input wire logic                  file_rd,
   input wire logic                  file_we,
   input wire logic [OLP_DATA_W-1:0] file_wdata,
   input wire logic [OLP_DATA_W-1:0] w_reg,
   input wire logic                  flag_negative,
   input wire logic                  flag_zero,
   input wire logic [1:0]            phase,
   input wire logic                  fetch_next,
   input wire logic [OLP_PTR_COUNT*OLP_LIT_W-1:0] indirect_pointer
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);

   phase_step_a: assert property (phase == 2'h3 |=> phase == 2'h0 ##1 phase == 2'h1)
      else $error("phase did not wrap in order");
   read_phase_a: assert property (file_rd |-> phase == 2'h1 ##1 !file_rd)
      else $error("operand read outside second phase");
   write_phase_a: assert property (file_we |-> phase == 2'h3 && $past(file_rd, 2))
      else $error("file write without matching read");
   or_result_a: assert property (file_we |-> file_wdata == (w_reg | $past(file_rdata)))
      else $error("written value is not the OR result");
   write_keeps_w_a: assert property (file_we |-> $stable(w_reg))
      else $error("working register changed on file write");
   flags_track_w_a: assert property ($changed(w_reg) |-> phase == 2'h3 && flag_zero == (w_reg == 8'h00)
      && flag_negative == w_reg[7])
      else $error("flags do not follow new working value");
   ptr_no_flags_a: assert property ($changed(indirect_pointer) |-> $stable(flag_zero) && $stable(flag_negative)
      && phase == 2'h3 && !$past(file_rd, 2))
      else $error("pointer load disturbed flags or timing");
   fetch_pulse_a: assert property (fetch_next == (phase == 2'h3))
      else $error("fetch request out of last phase");
   addr_hold_a: assert property ($changed(file_addr) |-> phase == 2'h1)
      else $error("operand address moved mid cycle");
endmodule // olp_exec_props

bind olp_exec olp_exec_props u_props (.clk, .reset_n, .file_rdata, .file_addr, .file_rd, .file_we, .file_wdata,
   .w_reg, .flag_negative, .flag_zero, .phase, .fetch_next, .indirect_pointer);

/* File: testbench.sv */
// Self-checking bench for the OR/pointer-load executor
`timescale 1ns/100ps
module testbench;
   import olp_pkg::*;
   logic        clk = 1'h0;
   logic        reset_n = 1'h0;
   logic [15:0] instr = 16'h0000;
   logic [3:0]  bank_sel = 4'h0;
   logic [7:0]  rdata = 8'h00;
   logic [7:0]  w_e = 8'h00;
   logic        n_e = 1'h0;
   logic        z_e = 1'h0;
   logic [35:0] ptr_e = 36'h0;
   wire  [11:0] f_addr;
   wire  [7:0]  f_wd, w;
   wire  [1:0]  ph;
   wire  [35:0] ptr;
   wire         f_rd, f_we, n, z, fetch;
   int          err_total = 0;
   int          n_compared = 0;
   int          cyc = 0;

   olp_exec dut_u (.clk(clk), .reset_n(reset_n), .instr_word(instr), .bank_select_register(bank_sel),
      .file_rdata(rdata), .file_addr(f_addr), .file_rd(f_rd), .file_we(f_we), .file_wdata(f_wd), .w_reg(w),
      .flag_negative(n), .flag_zero(z), .phase(ph), .fetch_next(fetch), .indirect_pointer(ptr));

   initial begin
      forever #2 clk = ~clk;
   end

   task automatic test_done;
      $display("compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input logic [35:0] got, exp, input string what);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // One instruction cycle: word presented in phase 0, outputs judged in phases 1 and 3
   task automatic run(input logic [15:0] word, input logic rd_e, we_e, input logic [11:0] a_e, input logic [7:0] wd_e);
      @(negedge clk);
      while (ph !== 2'h0) @(negedge clk);
      instr = word;
      @(negedge clk);
      chk(f_rd, rd_e, "read strobe");
      chk(ph, 2'h1, "phase");
      if (rd_e) chk(f_addr, a_e, "address");
      repeat (2) @(negedge clk);
      chk(fetch, 1'h1, "fetch");
      chk(f_we, we_e, "write strobe");
      if (we_e) chk(f_wd, wd_e, "write data");
      chk(w, w_e, "working reg");
      chk({n, z}, {n_e, z_e}, "flags");
      chk(ptr, ptr_e, "pointers");
   endtask

   task automatic or_op(input logic d, a, input logic [7:0] addr, rd);
      logic [7:0] res;
      logic [3:0] bank;
      res = w_e | rd;
      bank = a ? bank_sel : (addr < 8'h60 ? 4'h0 : 4'hF);
      rdata = rd;
      if (!d) w_e = res;
      n_e = res[7];
      z_e = (res == 8'h00);
      run({6'h04, d, a, addr}, 1'h1, d, {bank, addr}, res);
   endtask

   // Index 3 and a bad second word must be refused
   task automatic ptr_op(input logic [1:0] idx, input logic [11:0] lit, input logic good);
      if (idx != 2'h3) ptr_e[idx*12+8+:4] = lit[11:8];
      run({10'h3B8, idx, lit[11:8]}, 1'h0, 1'h0, 12'h000, 8'h00);
      if (idx != 2'h3 && good) ptr_e[idx*12+:8] = lit[7:0];
      run({good ? 8'hF0 : 8'hF1, lit[7:0]}, 1'h0, 1'h0, 12'h000, 8'h00);
   endtask

   initial begin
      repeat (5) @(posedge clk);
      @(negedge clk);
      reset_n = 1'h1;
      or_op(1'h1, 1'h0, 8'h5F, 8'h00);
      or_op(1'h0, 1'h0, 8'h60, 8'h91);
      bank_sel = 4'h5;
      or_op(1'h0, 1'h1, 8'h13, 8'h13);
      or_op(1'h1, 1'h1, 8'hFF, 8'h0C);
      ptr_op(2'h0, 12'h3AB, 1'h1);
      ptr_op(2'h1, 12'hC5A, 1'h1);
      ptr_op(2'h2, 12'hFFF, 1'h1);
      ptr_op(2'h3, 12'h123, 1'h1);
      ptr_op(2'h1, 12'h0E7, 1'h0);
      or_op(1'h0, 1'h0, 8'h00, 8'h60);
      test_done();
   end

   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         err_total++;
         test_done();
      end
   end
endmodule // testbench
